// file: tlec_top.sv
`timescale 1ns/100ps
// What this block does
// [RULE1] rising edge sets latch, two-cycle detection
// [RULE2] latch bit cleared when pending sets
// [RULE3] software writes latch only when masked
// [RULE4] only unmasked latched events are offered
// [RULE5] event mask access needs supervisor mode
// [RULE6] set/clear instructions gate general events
// [RULE7] pending hardware-owned, tracks nested events
// [RULE8] latch, mask, pending are 16 bits
// [RULE9] source mask, status, wakeup: 32-bit pairs
// [RULE10] source mask forwards or blocks requests
// [RULE11] source status shows live request level
// [RULE12] wakeup enable wakes idle or sleeping core
// [RULE13] shared sources tolerate overlapping pulses
// [RULE14] pending bits serve as source acknowledge
// [RULE15] next edge queued once pending sets
// [RULE16] edge to pending at least three cycles
// [RULE17] assignment fields route sources to events
module tlec_top import tlec_pkg::*; (
   input  wire logic               clk_i,
   input  wire logic               nrst_i,
   input  wire logic               hsel_i,
   input  wire logic [31:0]        haddr_i,
   input  wire logic [1:0]         htrans_i,
   input  wire logic               hwrite_i,
   input  wire logic [2:0]         hsize_i,
   input  wire logic [31:0]        hwdata_i,
   input  wire logic               hready_i,
   output logic      [31:0]        hrdata_o,
   output logic                    hreadyout_o,
   output logic                    hresp_o,
   input  wire logic [NUM_SRC-1:0] src_req_i,
   input  wire logic [6:0]         core_event_i,
   input  wire logic               supervisor_i,
   input  wire logic               core_idle_i,
   input  wire logic               core_sleep_i,
   input  wire logic               set_int_i,
   input  wire logic               clear_int_i,
   input  wire logic               core_accept_i,
   input  wire logic               core_return_i,
   output logic                    service_valid_o,
   output logic      [3:0]         service_event_o,
   output logic                    wake_o,
   output logic                    irq_o
);
   // ==========================================================
   // state
   logic [NUM_SRC-1:0]    src_sync;
   logic [31:0]           src_mask [2];
   logic [31:0]           src_wake [2];
   logic [31:0]           src_asg [NUM_ASG];
   logic [NUM_EVT-1:0]    event_latch;
   logic [NUM_EVT-1:0]    event_mask;
   logic [NUM_EVT-1:0]    event_pending;
   logic [NUM_GEN-1:0]    gen_line;
   logic [NUM_GEN-1:0]    ack_gap;
   logic [NUM_EVT-1:0]    ev_d1;
   logic [NUM_EVT-1:0]    ev_d2;
   logic                  gie;
   logic [IRQ_W-1:0]      irq_stat;
   logic [IRQ_W-1:0]      irq_en;
   logic                  dp_we;
   logic                  dp_sup;
   logic [7:0]            dp_addr;
   tlec_offer_t           offer;

   // ==========================================================
   // system stage
   tlec_sync #(
      .WIDTH (NUM_SRC)
   ) u_sync (
      .clk_i   (clk_i),
      .nrst_i  (nrst_i),
      .async_i (src_req_i),
      .sync_o  (src_sync)
   );

   wire [NUM_SRC-1:0] src_status = src_sync & SRC_VALID;                 // see [RULE11] [RULE17]
   wire [NUM_SRC-1:0] src_fwd    = src_status & {src_mask[1], src_mask[0]}; // see [RULE10]
   wire [NUM_SRC-1:0] src_wkhit  = src_status & {src_wake[1], src_wake[0]}; // see [RULE12]

   logic [NUM_GEN-1:0] src_route [NUM_SRC];
   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi++) begin : g_route
         wire [ASG_W-1:0] asg = src_asg[gi/8][ASG_W*(gi%8) +: ASG_W];
         assign src_route[gi] = (asg < ASG_W'(NUM_GEN)) ?                  // see [RULE17]
                                NUM_GEN'(1) << asg : '0;
      end
   endgenerate

   logic [NUM_GEN-1:0] any_req;
   always_comb begin
      any_req = '0;
      for (int i = 0; i < NUM_SRC; i++) begin
         any_req = any_req | (src_fwd[i] ? src_route[i] : '0);
      end
   end

   // ==========================================================
   // core stage edge detection and latch
   wire [NUM_EVT-1:0] ev_in    = {gen_line, core_event_i};
   wire [NUM_EVT-1:0] ev_rise  = ev_d1 & ~ev_d2;                          // see [RULE1]
   wire               accept   = core_accept_i & (offer == TLEC_OFFER);
   wire [NUM_EVT-1:0] pend_set = accept ? NUM_EVT'(1) << service_event_o : '0;

   logic [NUM_EVT-1:0] pend_clr;
   always_comb begin
      pend_clr = '0;
      for (int i = NUM_EVT - 1; i >= 0; i--) begin
         if (event_pending[i]) begin
            pend_clr = NUM_EVT'(1) << i;
         end
      end
      if (!core_return_i) begin
         pend_clr = '0;
      end
   end

   // ==========================================================
   // bus decode
   wire        ap_valid = hsel_i & htrans_i[1] & hready_i;
   wire [7:0]  ap_addr  = haddr_i[7:0];
   wire        wr_lat   = dp_we & (dp_addr == OFS_EVT_LATCH);
   wire        wr_msk   = dp_we & (dp_addr == OFS_EVT_MASK) & dp_sup;     // see [RULE5]
   wire        wr_clr   = dp_we & (dp_addr == OFS_IRQ_CLR);
   wire        wr_en    = dp_we & (dp_addr == OFS_IRQ_EN);
   wire        wr_asg   = dp_we & (dp_addr >= OFS_ASG_BASE) & (dp_addr <= OFS_ASG_LAST);
   wire [2:0]  asg_idx  = dp_addr[4:2];
   wire [15:0] lat_wbit = wr_lat ? ~event_mask : '0;                      // see [RULE3]
   wire        bad_lat  = wr_lat & |(hwdata_i[15:0] & event_mask ^ event_latch & event_mask);
   wire        bad_sup  = dp_we & ~dp_sup &
                          ((dp_addr == OFS_EVT_MASK) | (dp_addr == OFS_EVT_PEND));

   // set wins: an edge in the clearing cycle stays queued
   wire [NUM_EVT-1:0] next_latch = (event_latch & ~pend_set & ~lat_wbit) |
                                   (hwdata_i[15:0] & lat_wbit) | ev_rise; // see [RULE2] [RULE15]

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ev_d1       <= '0;
         ev_d2       <= '0;
         event_latch <= '0;
      end else begin
         ev_d1       <= ev_in;                                            // see [RULE1]
         ev_d2       <= ev_d1;
         event_latch <= next_latch;                                       // see [RULE8]
      end
   end

   // pending bit pulls the line low one cycle so a still-high share re-edges
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gen_line <= '0;
         ack_gap  <= '0;
      end else begin
         ack_gap  <= pend_set[NUM_EVT-1:FIRST_GEN];                       // see [RULE14]
         gen_line <= any_req & ~ack_gap;                                  // see [RULE13]
      end
   end

   // ==========================================================
   // offer: highest-priority serviceable event above current nesting
   wire [NUM_EVT-1:0] gie_gate = {{NUM_GEN{gie}}, {FIRST_GEN{1'b1}}};     // see [RULE6]
   wire [NUM_EVT-1:0] eligible = event_latch & event_mask & gie_gate;     // see [RULE4]

   logic       cand_valid;
   logic [3:0] cand_id;
   always_comb begin
      cand_valid = 1'b0;
      cand_id    = '0;
      for (int i = NUM_EVT - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            cand_valid = 1'b1;
            cand_id    = 4'(i);
         end
      end
      for (int i = 0; i < NUM_EVT; i++) begin
         if (event_pending[i] && (4'(i) <= cand_id)) begin
            cand_valid = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         offer           <= TLEC_IDLE;
         service_valid_o <= 1'b0;
         service_event_o <= '0;
         event_pending   <= '0;
         gie             <= 1'b0;
      end else begin
         event_pending <= (event_pending | pend_set) & ~pend_clr;         // see [RULE7]
         if (set_int_i) begin
            gie <= 1'b1;                                                  // see [RULE6]
         end else if (clear_int_i) begin
            gie <= 1'b0;
         end
         case (offer)
            TLEC_IDLE: begin
               if (cand_valid) begin
                  offer           <= TLEC_OFFER;
                  service_valid_o <= 1'b1;
                  service_event_o <= cand_id;
               end
            end
            TLEC_OFFER: begin
               // withdrawn offers re-evaluate; an event masked on the edge that raises its offer can still be taken
               offer           <= TLEC_IDLE;
               service_valid_o <= 1'b0;
            end
            default: begin
               offer           <= TLEC_IDLE;
               service_valid_o <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // registers written by software
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         src_mask   <= '{SRC_MASK_RST, SRC_MASK_RST};
         src_wake   <= '{SRC_WAKE_RST, SRC_WAKE_RST};
         src_asg    <= ASG_RST;
         event_mask <= EVT_MASK_RST;
         irq_en     <= '0;
      end else begin
         if (dp_we && dp_addr == OFS_SRC_MASK0) src_mask[0] <= hwdata_i; // see [RULE9]
         if (dp_we && dp_addr == OFS_SRC_MASK1) src_mask[1] <= hwdata_i;
         if (dp_we && dp_addr == OFS_SRC_WAKE0) src_wake[0] <= hwdata_i;
         if (dp_we && dp_addr == OFS_SRC_WAKE1) src_wake[1] <= hwdata_i;
         if (wr_asg) src_asg[asg_idx] <= hwdata_i;
         if (wr_msk) event_mask <= hwdata_i[15:0];
         if (wr_en) irq_en <= hwdata_i[IRQ_W-1:0];
      end
   end

   // ==========================================================
   // sticky status, wakeup and interrupt line
   wire wake_now = (core_idle_i | core_sleep_i) & |src_wkhit;             // see [RULE12]
   wire [IRQ_W-1:0] irq_set = {bad_lat | bad_sup, wake_now, |ev_rise};
   wire [IRQ_W-1:0] irq_clr = wr_clr ? hwdata_i[IRQ_W-1:0] : '0;
   wire [IRQ_W-1:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_set;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_stat <= '0;
         irq_o    <= 1'b0;
         wake_o   <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_o    <= |(next_irq_stat & irq_en);
         wake_o   <= wake_now;
      end
   end

   // ==========================================================
   // read mux; read data settle at the address phase, zero wait
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (ap_addr)
         OFS_SRC_MASK0: rd_mux = src_mask[0];
         OFS_SRC_MASK1: rd_mux = src_mask[1];
         OFS_SRC_STAT0: rd_mux = src_status[31:0];
         OFS_SRC_STAT1: rd_mux = src_status[63:32];
         OFS_SRC_WAKE0: rd_mux = src_wake[0];
         OFS_SRC_WAKE1: rd_mux = src_wake[1];
         OFS_EVT_LATCH: rd_mux = {16'h0000, event_latch};
         OFS_EVT_MASK:  rd_mux = supervisor_i ? {16'h0000, event_mask} : '0;    // see [RULE5]
         OFS_EVT_PEND:  rd_mux = supervisor_i ? {16'h0000, event_pending} : '0; // see [RULE7]
         OFS_IRQ_STAT:  rd_mux = {29'h0, irq_stat};
         OFS_IRQ_EN:    rd_mux = {29'h0, irq_en};
         OFS_CTRL_STAT: rd_mux = {31'h0, gie};
         default: begin
            if (ap_addr >= OFS_ASG_BASE && ap_addr <= OFS_ASG_LAST) begin
               rd_mux = src_asg[ap_addr[4:2]];
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dp_we       <= 1'b0;
         dp_sup      <= 1'b0;
         dp_addr     <= '0;
         hrdata_o    <= '0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         dp_we       <= ap_valid & hwrite_i;
         dp_sup      <= supervisor_i;
         dp_addr     <= ap_addr;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         if (ap_valid && !hwrite_i) begin
            hrdata_o <= rd_mux;
         end
      end
   end

   // ==========================================================
   // checks
   sequence s_fresh_edge7;
      $rose(ev_in[7]) && !event_pending[7] && !event_latch[7] && !service_valid_o;
   endsequence

   a_latch_on_edge: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE1]
      (ev_rise != 0 && !wr_lat) |=> ((event_latch & $past(ev_rise)) == $past(ev_rise)))
      else $error("edge did not set latch");
   a_latch_clr_pend: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE2]
      (pend_set != 0 && (pend_set & ev_rise) == 0 && !wr_lat) |=>
      ((event_latch & $past(pend_set)) == 0))
      else $error("latch kept after pending set");
   a_mask_gates_offer: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE4]
      $rose(service_valid_o) |->
      (($past(event_mask & event_latch) & (NUM_EVT'(1) << service_event_o)) != 0))
      else $error("masked event offered");
   a_global_gate: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE6]
      (service_valid_o && service_event_o >= 4'(FIRST_GEN)) |-> $past(gie))
      else $error("general event offered while disabled");
   a_pend_hw_only: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE7]
      (!accept && !core_return_i) |=> $stable(event_pending))
      else $error("pending changed without core action");
   a_sup_guard: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE5]
      (dp_we && !dp_sup && dp_addr == OFS_EVT_MASK) |=> $stable(event_mask))
      else $error("mask written outside supervisor");
   a_fwd_blocked: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE10]
      (src_fwd == 0) |=> (gen_line == 0))
      else $error("blocked request reached core stage");
   a_wake_follow: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE12]
      wake_now |=> wake_o)
      else $error("wakeup not raised");
   a_ack_gap: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE14]
      pend_set[FIRST_GEN] |=> ##1 !gen_line[0])
      else $error("acknowledge gap missing");
   a_min_latency: assert property (@(posedge clk_i) disable iff (!nrst_i) // see [RULE16]
      s_fresh_edge7 |-> !event_pending[7] [*3])
      else $error("pending too soon after edge");
endmodule

// file: tlec_pkg.sv
package tlec_pkg;

   // ==========================================================
   // sizes
   localparam int NUM_SRC   = 64;
   localparam int NUM_EVT   = 16;
   localparam int NUM_GEN   = 9;
   localparam int FIRST_GEN = 7;
   localparam int NUM_ASG   = 8;
   localparam int ASG_W     = 4;

   // ==========================================================
   // timing, in core clock cycles
   localparam int EDGE_CYCLES    = 2;
   localparam int MIN_PEND_DELAY = 3;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_SRC_MASK0  = 8'h00;
   localparam logic [7:0] OFS_SRC_MASK1  = 8'h04;
   localparam logic [7:0] OFS_SRC_STAT0  = 8'h08;
   localparam logic [7:0] OFS_SRC_STAT1  = 8'h0C;
   localparam logic [7:0] OFS_SRC_WAKE0  = 8'h10;
   localparam logic [7:0] OFS_SRC_WAKE1  = 8'h14;
   localparam logic [7:0] OFS_EVT_LATCH  = 8'h18;
   localparam logic [7:0] OFS_EVT_MASK   = 8'h1C;
   localparam logic [7:0] OFS_EVT_PEND   = 8'h20;
   localparam logic [7:0] OFS_IRQ_STAT   = 8'h24;
   localparam logic [7:0] OFS_IRQ_CLR    = 8'h28;
   localparam logic [7:0] OFS_IRQ_EN     = 8'h2C;
   localparam logic [7:0] OFS_CTRL_STAT  = 8'h30;
   localparam logic [7:0] OFS_ASG_BASE   = 8'h40;
   localparam logic [7:0] OFS_ASG_LAST   = 8'h5C;

   // ==========================================================
   // irq status bit positions
   localparam int IRQ_W          = 3;
   localparam int IRQ_EDGE_BIT   = 0;
   localparam int IRQ_WAKE_BIT   = 1;
   localparam int IRQ_REFUSE_BIT = 2;

   // ==========================================================
   // reset values and the map of valid sources
   localparam logic [31:0] SRC_MASK_RST = 32'h00000000;
   localparam logic [31:0] SRC_WAKE_RST = 32'h00000000;
   localparam logic [15:0] EVT_MASK_RST = 16'h001F;
   localparam logic [63:0] SRC_VALID    = 64'h00F9FFFF7FFFF7FF;
   localparam logic [31:0] ASG_RST [NUM_ASG] = '{
      32'h00000000, 32'h22110000, 32'h33332222, 32'h04444433,
      32'h55555555, 32'h06666655, 32'h33333003, 32'h00000000};

   // ==========================================================
   // offer state
   typedef enum logic [1:0] {
      TLEC_IDLE  = 2'b01,
      TLEC_OFFER = 2'b10
   } tlec_offer_t;

endpackage

// file: tlec_sync.sv
`timescale 1ns/100ps
module tlec_sync #(
   parameter int WIDTH = 64
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   // ==========================================================
   // two flops; first stage read only by the second
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule

// file: tlec_core_model.sv
`timescale 1ns/100ps
module tlec_core_model (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic service_valid_i,
   input  wire logic accept_en_i,
   input  wire logic slow_i,
   input  wire logic ret_req_i,
   output logic      core_accept_o,
   output logic      core_return_o
);
   // ==========================================================
   // core pipeline stand-in
   logic seen;

   // a slow core lets the first offer pass and takes the re-offer
   assign core_accept_o = service_valid_i & accept_en_i & (~slow_i | seen);
   assign core_return_o = ret_req_i;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         seen <= 1'b0;
      end else if (service_valid_i) begin
         seen <= ~core_accept_o;
      end
   end
endmodule

// file: tb_tlec_top.sv
`timescale 1ns/100ps
module tb_tlec_top import tlec_pkg::*;;
   // ==========================================================
   // stimulus and observation
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic [63:0] src = 64'h0;
   logic [6:0]  cev = 7'h00;
   logic        sup = 1'b1, idle = 1'b0, sleep = 1'b0, seti = 1'b0, clri = 1'b0;
   logic        acc_en = 1'b1, slow = 1'b0, ret_req = 1'b0;
   logic        acc, ret, hreadyout, hresp, sv, wake, irq;
   logic [31:0] hrdata;
   logic [3:0]  sev;
   int          err_total = 0;
   int          cmp_count = 0;
   int          tick = 0;
   int          n;

   always #2 clk_i = ~clk_i;

   tlec_top tlec_top_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
      .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
      .hresp_o(hresp), .src_req_i(src), .core_event_i(cev), .supervisor_i(sup),
      .core_idle_i(idle), .core_sleep_i(sleep), .set_int_i(seti),
      .clear_int_i(clri), .core_accept_i(acc), .core_return_i(ret),
      .service_valid_o(sv), .service_event_o(sev), .wake_o(wake), .irq_o(irq)
   );

   tlec_core_model tlec_core_model_i (
      .clk_i(clk_i), .nrst_i(nrst_i), .service_valid_i(sv), .accept_en_i(acc_en),
      .slow_i(slow), .ret_req_i(ret_req), .core_accept_o(acc), .core_return_o(ret)
   );

   // ==========================================================
   // shared tasks
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_i);
   endtask

   // one single word transfer; ends one idle cycle later so a read
   // right after a write never sees the old value
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk_i);
      while (hreadyout !== 1'b1) @(posedge clk_i);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk_i);
      while (hreadyout !== 1'b1) @(posedge clk_i);
      q = hrdata;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      check(q, exp);
   endtask

   task automatic wait_offer();
      n = 0;
      while (sv !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      check({27'h0, hreadyout, hresp, sv, wake, irq}, 32'h10);
      rdc(OFS_EVT_MASK, 32'h0000001F);
      rdc(OFS_SRC_MASK0, 32'h0);
      rdc(OFS_SRC_WAKE1, 32'h0);
      for (int i = 0; i < NUM_ASG; i++) rdc(OFS_ASG_BASE + 8'(4 * i), ASG_RST[i]);
   endtask

   task automatic t_regs();
      wr(OFS_SRC_MASK1, 32'hFFFFFFFF);
      rdc(OFS_SRC_MASK1, 32'hFFFFFFFF);
      wr(OFS_SRC_MASK1, 32'h0);
      wr(OFS_EVT_PEND, 32'hFFFF);
      rdc(OFS_EVT_PEND, 32'h0);
      wr(8'h38, 32'hFFFFFFFF);
      rdc(8'h38, 32'h0);
      wr(OFS_EVT_MASK, 32'hFFFFFFFF);
      rdc(OFS_EVT_MASK, 32'h0000FFFF);
      wr(OFS_EVT_MASK, 32'h1F);
   endtask

   task automatic t_priv();
      wr(OFS_IRQ_EN, 32'h4);
      sup <= 1'b0;
      wr(OFS_EVT_MASK, 32'h0);
      rdc(OFS_EVT_MASK, 32'h0);
      sup <= 1'b1;
      cyc(2);
      check({31'h0, irq}, 32'h1);
      rdc(OFS_EVT_MASK, 32'h1F);
      rdc(OFS_IRQ_STAT, 32'h4);
      wr(OFS_IRQ_EN, 32'h0);
      cyc(2);
      check({31'h0, irq}, 32'h0);
      wr(OFS_IRQ_EN, 32'h4);
      wr(OFS_IRQ_CLR, 32'h4);
      cyc(2);
      check({31'h0, irq}, 32'h0);
   endtask

   task automatic t_core();
      acc_en <= 1'b0;
      cev[3] <= 1'b1;
      wait_offer();
      check({31'h0, sv}, 32'h1);
      check(32'(n >= 3), 32'h1);
      check({28'h0, sev}, 32'h3);
      rdc(OFS_EVT_LATCH, 32'h8);
      acc_en <= 1'b1;
      slow <= 1'b1;
      cyc(6);
      rdc(OFS_EVT_PEND, 32'h8);
      rdc(OFS_EVT_LATCH, 32'h0);
      cev[3] <= 1'b0;
      cyc(2);
      cev[3] <= 1'b1;
      cyc(4);
      rdc(OFS_EVT_LATCH, 32'h8);
      ret_req <= 1'b1;
      cyc(1);
      ret_req <= 1'b0;
      cyc(8);
      rdc(OFS_EVT_LATCH, 32'h0);
      ret_req <= 1'b1;
      cev[3] <= 1'b0;
      slow <= 1'b0;
      cyc(1);
      ret_req <= 1'b0;
      cyc(2);
      rdc(OFS_EVT_PEND, 32'h0);
   endtask

   task automatic t_mask();
      wr(OFS_EVT_MASK, 32'h0F);
      cev[4] <= 1'b1;
      cyc(12);
      rdc(OFS_EVT_PEND, 32'h0);
      rdc(OFS_EVT_LATCH, 32'h10);
      // software touches the latch only while the event is masked
      wr(OFS_EVT_LATCH, 32'h0);
      rdc(OFS_EVT_LATCH, 32'h0);
      cev[4] <= 1'b0;
      wr(OFS_EVT_MASK, 32'h1F);
   endtask

   task automatic t_src();
      wr(OFS_EVT_MASK, 32'h9F);
      wr(OFS_SRC_MASK0, 32'h1);
      src[0] <= 1'b1;
      cyc(10);
      rdc(OFS_SRC_STAT0, 32'h1);
      rdc(OFS_EVT_LATCH, 32'h80);
      rdc(OFS_EVT_PEND, 32'h0);
      seti <= 1'b1;
      cyc(1);
      seti <= 1'b0;
      cyc(10);
      rdc(OFS_CTRL_STAT, 32'h1);
      rdc(OFS_EVT_PEND, 32'h80);
      rdc(OFS_EVT_LATCH, 32'h80);
      clri <= 1'b1;
      ret_req <= 1'b1;
      cyc(1);
      clri <= 1'b0;
      ret_req <= 1'b0;
      cyc(8);
      rdc(OFS_EVT_PEND, 32'h0);
      wr(OFS_SRC_MASK0, 32'h0);
      wr(OFS_EVT_MASK, 32'h1F);
      wr(OFS_EVT_LATCH, 32'h0);
      src[0] <= 1'b0;
      cyc(6);
      src[0] <= 1'b1;
      cyc(10);
      rdc(OFS_SRC_STAT0, 32'h1);
      rdc(OFS_EVT_LATCH, 32'h0);
   endtask

   task automatic t_wake();
      wr(OFS_SRC_WAKE0, 32'h1);
      wr(OFS_IRQ_EN, 32'h2);
      idle <= 1'b1;
      cyc(4);
      check({31'h0, wake}, 32'h1);
      idle <= 1'b0;
      sleep <= 1'b1;
      cyc(3);
      check({31'h0, wake}, 32'h1);
      sleep <= 1'b0;
      cyc(3);
      check({30'h0, wake, irq}, 32'h1);
      wr(OFS_IRQ_CLR, 32'h7);
      cyc(2);
      check({31'h0, irq}, 32'h0);
   endtask

   task automatic t_rsvd();
      // source 11 is outside the valid map and source 0 is still high, so only bit 0 may show
      src[11] <= 1'b1;
      cyc(6);
      rdc(OFS_SRC_STAT0, 32'h1);
      // rerouting a live source gives its new event a fresh edge
      wr(OFS_ASG_BASE, 32'h1);
      wr(OFS_SRC_MASK0, 32'h1);
      cyc(6);
      rdc(OFS_EVT_LATCH, 32'h100);
      rdc(OFS_IRQ_STAT, 32'h1);
      src <= 64'h0;
   endtask

   // ==========================================================
   // run control
   always @(posedge clk_i) begin
      tick++;
      if (tick == 5000) begin
         err_total++;
         wrap_up();
      end
   end

   initial begin
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_regs();
      t_priv();
      t_core();
      t_mask();
      t_src();
      t_wake();
      t_rsvd();
      wrap_up();
   end
endmodule
